// ---- common/latch_blink_map.svh ----
// constants for the latching switch logic with blink output
// assumes a 250 MHz system clock; included by the design and the bench
`ifndef LATCH_BLINK_MAP_SVH
`define LATCH_BLINK_MAP_SVH
`define CLK_PERIOD_NS 4
`define CLEAR_MIN_MS 120
`define PULSE_MIN_MS 45
`define BLINK_HZ 1
`define POWER_LOSS_MAX_S 5
`define MS_CYCLES(ms) ((ms) * 1000000 / `CLK_PERIOD_NS)
`define CLEAR_MIN_CYC `MS_CYCLES(`CLEAR_MIN_MS)
`define PULSE_MIN_CYC `MS_CYCLES(`PULSE_MIN_MS)
`define BLINK_HALF_CYC (1000000000 / `CLK_PERIOD_NS / `BLINK_HZ / 2)
`define STATE_RST 1'b0
`endif

// ---- common/latch_blink_pkg.sv ----
// types for the latching switch logic with blink output
// assumes nothing beyond the constants header
package latch_blink_pkg;
   typedef enum logic [1:0] {FLASH_OFF, FLASH_STEADY, FLASH_BLINK} flash_mode_t;
   typedef struct packed
   {
      logic clear;
      logic force_on;
      logic flip;
   } ctl_req_t;
   typedef struct packed
   {
      logic state_oe_n;
      logic state_inv_oe_n;
      logic flash_oe_n;
   } od_drive_t;
endpackage : latch_blink_pkg

// ---- testbench/latch_blink_fast_map.svh ----
// short timing counts for the bench, handed to the design as parameter overrides
// assumes the design's constants header for the millisecond figures
`ifndef LATCH_BLINK_FAST_MAP_SVH
`define LATCH_BLINK_FAST_MAP_SVH
`include "latch_blink_map.svh"
// four cycles stand for a millisecond and the blink half period is cut, so a run stays short
`define FAST_CYC_PER_MS 4
`define FAST_CLEAR_CYC (`CLEAR_MIN_MS * `FAST_CYC_PER_MS)
`define FAST_PULSE_CYC (`PULSE_MIN_MS * `FAST_CYC_PER_MS)
`define FAST_HALF_CYC 200
`endif

// ---- testbench/latching_switch_logic_blink_tb.sv ----
// self-checking bench: pulses the request pins, checks the pulled-up output levels
// assumes the design takes its timing counts as parameters; the bench shortens them
`timescale 1ns/100ps
`include "latch_blink_fast_map.svh"
module latching_switch_logic_blink_tb;
   import latch_blink_pkg::*;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   ctl_req_t req = '0;
   logic so, soe, sio, sioe, fo, foe, q, qn, fl;
   int n_errors = 0;
   int checked = 0;
   int s = 0;
   int m = 0;
   // the last entry breaks the pairing rule on purpose to check the outputs
   logic [2:0] kinds [8] = '{3'h1, 3'h1, 3'h1, 3'h2, 3'h4, 3'h4, 3'h1, 3'h6};
   bit longs [8] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
   always #2 sys_clk = ~sys_clk;
   latching_switch_logic_blink #(.CLEAR_CYC(`FAST_CLEAR_CYC), .PULSE_CYC(`FAST_PULSE_CYC),
      .HALF_CYC(`FAST_HALF_CYC)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .latch_clear_n(~req.clear), .latch_force_n(~req.force_on), .flip_request_n(~req.flip),
      .state_out_o(so), .state_out_oe_n(soe), .state_out_inverted_o(sio),
      .state_out_inverted_oe_n(sioe), .flash_out_o(fo), .flash_out_oe_n(foe));
   od_load_model load (.state_out_o(so), .state_out_oe_n(soe), .state_out_inverted_o(sio),
      .state_out_inverted_oe_n(sioe), .flash_out_o(fo), .flash_out_oe_n(foe),
      .q_lvl(q), .qn_lvl(qn), .flash_lvl(fl));
   ////////////////////////////////////////////////////////////////////////////////
   task chk(input logic seen, input logic exp, input string what);
      checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[FAIL] %0t %s", $time, what);
      end
   endtask : chk
   // m: 0 released, 1 steady low, 2 blinking
   task outs(input logic eq, input logic eqn);
      logic v;
      int k;
      // look between edges so the outputs have settled
      @(negedge sys_clk);
      chk(q, eq, "state_out level");
      chk(qn, eqn, "state_out_inverted level");
      chk(so | sio | fo, 1'b0, "open-drain data");
      if (m == 2)
      begin
         v = fl;
         k = 0;
         while (fl === v && k < `FAST_HALF_CYC + 4)
         begin
            @(negedge sys_clk);
            k++;
         end
         chk(fl !== v, 1'b1, "flash not blinking");
      end
      else
         repeat (8) @(negedge sys_clk) chk(fl, m != 1, "flash level");
   endtask : outs
   task press(input ctl_req_t r, input bit lng);
      int mn;
      int w;
      mn = r.clear ? `FAST_CLEAR_CYC : `FAST_PULSE_CYC;
      w = lng ? mn + 10 + $urandom % 30 : mn - 20 - $urandom % (mn / 2);
      @(posedge sys_clk) req <= r;
      repeat (w) @(posedge sys_clk);
      if (lng && (r.clear || r.force_on))
      begin
         s = r.clear ? 0 : 1;
         m = r.clear ? 1 : 2;
         outs(r.clear ? !r.force_on : 1'b0, s[0]);
      end
      @(posedge sys_clk) req <= '0;
      repeat (12) @(posedge sys_clk);
      if (lng && r.clear)
         m = 0;
      if (lng && r == 3'h1)
      begin
         s ^= 1;
         m = (m == 2) ? 0 : 2;
      end
      outs(!s[0], s[0]);
   endtask : press
   task tally_and_finish;
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : tally_and_finish
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (40 * (`FAST_CLEAR_CYC + `FAST_HALF_CYC)) @(posedge sys_clk);
      n_errors++;
      tally_and_finish();
   end
   initial
   begin
      void'($urandom(32'hc6eaaaaf));
      repeat (3) @(posedge sys_clk);
      sys_rst <= 1'b0;
      outs(1'b1, 1'b0);
      for (int i = 0; i < 8; i++)
      begin
         press(kinds[i], longs[i]);
         $display("test %0d done", i);
      end
      tally_and_finish();
   end
endmodule : latching_switch_logic_blink_tb

// ---- testbench/od_load_model.sv ----
// loads on the three open-drain outputs, each with a pull-up
// assumes the design's data and active-low enable pairs
`timescale 1ns/100ps
module od_load_model (
   input wire logic state_out_o,
   input wire logic state_out_oe_n,
   input wire logic state_out_inverted_o,
   input wire logic state_out_inverted_oe_n,
   input wire logic flash_out_o,
   input wire logic flash_out_oe_n,
   output logic q_lvl,
   output logic qn_lvl,
   output logic flash_lvl
);
   // a released line floats up to the pull-up level
   assign q_lvl = state_out_oe_n ? 1'b1 : state_out_o;
   assign qn_lvl = state_out_inverted_oe_n ? 1'b1 : state_out_inverted_o;
   assign flash_lvl = flash_out_oe_n ? 1'b1 : flash_out_o;
endmodule : od_load_model

// ---- verilog/latching_switch_logic_blink.sv ----
// latching switch logic: three debounced active-low requests, one stored state,
// open-drain outputs. assumes inputs are asynchronous pins with pull-ups outside.
`timescale 1ns/100ps
`include "latch_blink_map.svh"

// What this block does
// RL1 - while clear is held, state_out is released, the inverted output is pulled low, off is stored.
// RL2 - while force is held, state_out is pulled low, the inverted output is released, flash blinks.
// RL3 - with clear and force both idle, each flip request accepted after a full width low inverts the stored state.
// RL4 - flash_out is held steadily low for as long as clear is held.
// RL5 - when clear is released, flash_out goes to the released off condition.
// RL6 - each accepted flip toggles flash_out between blinking and off, except one accepted in the cycle clear is released, which sets it off.
// RL7 - flash_out has exactly three conditions: off, steady low and blinking.
// RL8 - every output is open drain, pulled low when asserted and released otherwise.
// RL9 - the driver holds clear low at least 120 ms and force or flip low at least 45 ms.
// RL10 - after power loss the device comes back cleared within 5 seconds.
// RL11 - a free-running 1 Hz square wave is gated onto flash_out only when blinking.
// RL12 - all three control inputs are debounced before they act.
// RL13 - the stored state holds indefinitely between requests.
// RL14 - clear and force together are illegal and pull both state outputs low, flash steady.
// RL15 - low pulses shorter than the minimum width of an input cause no change.
module latching_switch_logic_blink
   import latch_blink_pkg::*;
// counts default to the real timing; a bench may shorten them to keep runs small
#(
   parameter int unsigned CLEAR_CYC = `CLEAR_MIN_CYC,
   parameter int unsigned PULSE_CYC = `PULSE_MIN_CYC,
   parameter int unsigned HALF_CYC = `BLINK_HALF_CYC
)
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic latch_clear_n,
   input wire logic latch_force_n,
   input wire logic flip_request_n,
   output logic state_out_o,
   output logic state_out_oe_n,
   output logic state_out_inverted_o,
   output logic state_out_inverted_oe_n,
   output logic flash_out_o,
   output logic flash_out_oe_n
);

   ////////////////////////////////////////////////////////////////////////////////
   // synchronise and debounce; a request counts only once it held low a full width
   logic [2:0] raw_n;
   logic [2:0] s1_q, s2_q, s3_q;
   logic [2:0] low_q;
   logic [27:0] cnt_q [3];
   ctl_req_t req;

   assign raw_n = {latch_clear_n, latch_force_n, flip_request_n};

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         s1_q <= 3'h7;
         s2_q <= 3'h7;
         s3_q <= 3'h7;
      end
      else
      begin
         s1_q <= raw_n;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   function automatic logic [27:0] width_of(input int idx);
      width_of = (idx == 2) ? 28'(CLEAR_CYC) : 28'(PULSE_CYC);
   endfunction : width_of

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_deb
         // counts only while both late stages agree low; a high in both late stages restarts the count
         always_ff @(posedge sys_clk or posedge sys_rst)
         begin
            if (sys_rst)
            begin
               cnt_q[gi] <= 28'h0;
               low_q[gi] <= 1'b0;
            end
            else if (s2_q[gi] && s3_q[gi])
            begin
               cnt_q[gi] <= 28'h0;
               low_q[gi] <= 1'b0; // see RL15
            end
            else if (!s2_q[gi] && !s3_q[gi])
            begin
               if (cnt_q[gi] >= width_of(gi) - 28'h1)
                  low_q[gi] <= 1'b1; // see RL12
               else
                  cnt_q[gi] <= cnt_q[gi] + 28'h1;
            end
         end
      end
   endgenerate

   assign req = '{clear: low_q[2], force_on: low_q[1], flip: low_q[0]};

   ////////////////////////////////////////////////////////////////////////////////
   // stored state and flash mode
   logic state_q;
   logic flip_seen_q;
   logic flip_evt;
   flash_mode_t mode_q;

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         flip_seen_q <= 1'b0;
      else
         flip_seen_q <= req.flip;
   end

   assign flip_evt = req.flip && !flip_seen_q && !req.clear && !req.force_on;

   // reset is the power-up path: the device starts cleared
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         state_q <= `STATE_RST; // see RL10
      else if (req.clear)
         state_q <= 1'b0; // see RL1
      else if (req.force_on)
         state_q <= 1'b1; // see RL2
      else if (flip_evt)
         state_q <= !state_q; // see RL3
   end // holds otherwise, see RL13

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         mode_q <= FLASH_OFF;
      else if (req.clear)
         mode_q <= FLASH_STEADY; // see RL4
      else if (req.force_on)
         mode_q <= FLASH_BLINK; // see RL2
      else if (mode_q == FLASH_STEADY)
         mode_q <= FLASH_OFF; // see RL5
      else if (flip_evt)
         mode_q <= (mode_q == FLASH_BLINK) ? FLASH_OFF : FLASH_BLINK; // see RL6
   end

   ////////////////////////////////////////////////////////////////////////////////
   // free-running 1 Hz square wave
   logic [27:0] half_q;
   logic wave_q;

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         half_q <= 28'h0;
         wave_q <= 1'b0;
      end
      else if (half_q == 28'(HALF_CYC - 1))
      begin
         half_q <= 28'h0;
         wave_q <= !wave_q; // see RL11
      end
      else
         half_q <= half_q + 28'h1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // open-drain drivers: data always low, enable low means pulling to ground
   od_drive_t drv_d, drv_q;

   always_comb
   begin
      drv_d.state_oe_n = !(state_q || (req.clear && req.force_on)); // see RL14
      drv_d.state_inv_oe_n = state_q && !(req.clear && req.force_on); // see RL14
      case (mode_q) // see RL7
         FLASH_STEADY: drv_d.flash_oe_n = 1'b0;
         FLASH_BLINK: drv_d.flash_oe_n = wave_q; // see RL11
         default: drv_d.flash_oe_n = 1'b1;
      endcase
   end

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         drv_q <= '{state_oe_n: 1'b1, state_inv_oe_n: 1'b0, flash_oe_n: 1'b1};
         state_out_o <= 1'b0;
         state_out_inverted_o <= 1'b0;
         flash_out_o <= 1'b0;
      end
      else
      begin
         drv_q <= drv_d; // see RL8
         state_out_o <= 1'b0;
         state_out_inverted_o <= 1'b0;
         flash_out_o <= 1'b0;
      end
   end

   assign state_out_oe_n = drv_q.state_oe_n;
   assign state_out_inverted_oe_n = drv_q.state_inv_oe_n;
   assign flash_out_oe_n = drv_q.flash_oe_n;

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   sequence clear_held;
      req.clear && !req.force_on;
   endsequence

   sequence force_held;
      req.force_on && !req.clear;
   endsequence

   // the illegal pair: clear and force accepted together
   sequence pair_held;
      req.clear && req.force_on;
   endsequence

   AST_CLEAR_OUTPUTS: assert property (@(posedge sys_clk) disable iff (sys_rst) // see RL1
      clear_held ##1 clear_held |=> state_out_oe_n && !state_out_inverted_oe_n)
      else $error("clear did not release state_out");
   AST_CLEAR_FLASH: assert property (@(posedge sys_clk) disable iff (sys_rst) // see RL4
      clear_held ##1 clear_held |=> !flash_out_oe_n)
      else $error("flash not steady during clear");
   AST_FORCE_OUTPUTS: assert property (@(posedge sys_clk) disable iff (sys_rst) // see RL2
      force_held ##1 force_held |=> !state_out_oe_n && state_out_inverted_oe_n
      && mode_q == FLASH_BLINK)
      else $error("force did not set state");
   AST_ILLEGAL_PAIR: assert property (@(posedge sys_clk) disable iff (sys_rst) // see RL14
      pair_held ##1 pair_held |=> !state_out_oe_n && !state_out_inverted_oe_n
      && !flash_out_oe_n)
      else $error("clear with force did not pull every output low");
   AST_FLIP_TOGGLE: assert property (@(posedge sys_clk) disable iff (sys_rst) // see RL3
      flip_evt |=> state_q != $past(state_q))
      else $error("flip did not invert state");
   AST_CLEAR_END: assert property (@(posedge sys_clk) disable iff (sys_rst) // see RL5
      !req.clear && !req.force_on && mode_q == FLASH_STEADY |=> ##1 flash_out_oe_n)
      else $error("flash not released after clear");
   AST_FLIP_FLASH: assert property (@(posedge sys_clk) disable iff (sys_rst) // see RL6
      flip_evt && mode_q != FLASH_STEADY |=> mode_q != $past(mode_q))
      else $error("flip did not toggle flash mode");
   AST_HOLD: assert property (@(posedge sys_clk) disable iff (sys_rst) // see RL13
      !req.clear && !req.force_on && !flip_evt |=> $stable(state_q))
      else $error("state changed without request");
   AST_SHORT_PULSE: assert property (@(posedge sys_clk) disable iff (sys_rst) // see RL15
      s2_q[0] && s3_q[0] |=> !low_q[0])
      else $error("flip accepted after high input");
   AST_OPEN_DRAIN: assert property (@(posedge sys_clk) disable iff (sys_rst) // see RL8
      !state_out_o && !state_out_inverted_o && !flash_out_o)
      else $error("open-drain output drove high");

endmodule : latching_switch_logic_blink
